/* pkg/srs_pkg.sv */
// package: constants and types for the two-wire serial register slave
package srs_pkg;
   localparam logic [6:0] ADDR_DEFAULT = 7'h36;  // 0x6c/0x6d
   localparam logic [6:0] ADDR_ALT     = 7'h37;  // 0x6e/0x6f
   localparam int         BYTE_BITS    = 8;
   localparam logic [2:0] BIT_LAST     = 3'h7;
   localparam logic [15:0] PTR_RESET   = 16'h0000;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   localparam logic [2:0]  CNT_RESET   = 3'h0;

   typedef enum logic [2:0] {
      SRS_IDLE   = 3'b000,
      SRS_DEVADR = 3'b001,
      SRS_ADRHI  = 3'b011,
      SRS_ADRLO  = 3'b010,
      SRS_WDATA  = 3'b110,
      SRS_RDATA  = 3'b111,
      SRS_IGNORE = 3'b101
   } srs_state_type;
endpackage

/* hdl/srs_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module srs_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

/* hdl/srs_slave.sv */
// two-wire serial register slave: link logic on the serial clock, register port on clk
`timescale 1ns/1ps
module srs_slave (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic        scl,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic        alt_addr_en,
   input  wire logic        alt_addr_sel,
   output logic [15:0]      reg_addr,
   output logic [7:0]       reg_wdata,
   output logic             reg_we,
   output logic             reg_rd,
   input  wire logic [7:0]  reg_rdata,
   output logic             busy
);
   // link domain: clocked by the serial clock itself
   srs_pkg::srs_state_type state_q;
   logic [2:0]  bit_q;
   logic        ack_q;
   logic [7:0]  shift_q;
   logic [7:0]  tx_q;
   logic        rw_q;
   logic        drive_q;
   logic [15:0] ptr_q;
   logic        start_t_q;
   logic        stop_t_q;
   logic        start_seen_q;
   logic        start_ack_q;
   logic        wr_t_q;
   logic        rd_t_q;
   logic [15:0] wr_addr_q;
   logic [7:0]  wr_data_q;
   logic [15:0] rd_addr_q;
   logic        in_frame_q;
   logic        adr_ack_q;
   logic [1:0]  alt_s;
   logic [7:0]  rdata_s_q;

   wire logic [6:0] my_addr = (alt_s[0] && alt_s[1]) ? srs_pkg::ADDR_ALT
                                                      : srs_pkg::ADDR_DEFAULT;
   wire logic [7:0] rx_byte = {shift_q[6:0], sda_i};

   // start and stop detection on data edges while clock high
   always_ff @(negedge sda_i or negedge nrst) begin
      if (!nrst) begin
         start_t_q <= 1'b0;
      end else if (scl) begin
         start_t_q <= ~start_t_q;
      end
   end

   always_ff @(posedge sda_i or negedge nrst) begin
      if (!nrst) begin
         stop_t_q <= 1'b0;
      end else if (scl) begin
         stop_t_q <= ~stop_t_q;
      end
   end

   always_ff @(negedge scl or negedge nrst) begin
      if (!nrst) begin
         start_ack_q <= 1'b0;
      end else begin
         start_ack_q <= start_t_q;
      end
   end

   always_ff @(posedge scl or negedge nrst) begin
      if (!nrst) begin
         start_seen_q <= 1'b0;
      end else begin
         start_seen_q <= start_t_q;
      end
   end

   // alternate address select crosses into the link domain
   srs_sync #(.WIDTH(2)) u_alt_sync (
      .clk  (scl),
      .nrst (nrst),
      .d    ({alt_addr_en, alt_addr_sel}),
      .q    (alt_s)
   );

   // bit receive and protocol state on rising serial clock
   always_ff @(posedge scl or negedge nrst) begin
      if (!nrst) begin
         state_q   <= srs_pkg::SRS_IDLE;
         bit_q     <= srs_pkg::CNT_RESET;
         ack_q     <= 1'b0;
         shift_q   <= srs_pkg::BYTE_RESET;
         rw_q      <= 1'b0;
         ptr_q     <= srs_pkg::PTR_RESET;
         wr_t_q    <= 1'b0;
         rd_t_q    <= 1'b0;
         wr_addr_q <= srs_pkg::PTR_RESET;
         wr_data_q <= srs_pkg::BYTE_RESET;
         rd_addr_q <= srs_pkg::PTR_RESET;
         adr_ack_q <= 1'b0;
      end else if (start_seen_q != start_t_q) begin
         // first bit after a start or restart
         state_q   <= srs_pkg::SRS_DEVADR;
         shift_q   <= {7'h00, sda_i};
         bit_q     <= 3'h1;
         ack_q     <= 1'b0;
         adr_ack_q <= 1'b0;
      end else if (ack_q) begin
         ack_q <= 1'b0;
         bit_q <= srs_pkg::CNT_RESET;
         if (state_q == srs_pkg::SRS_RDATA && sda_i) begin
            state_q <= srs_pkg::SRS_IGNORE;
         end
      end else if (state_q != srs_pkg::SRS_IDLE && state_q != srs_pkg::SRS_IGNORE) begin
         shift_q <= rx_byte;
         bit_q   <= bit_q + 3'h1;
         if (bit_q == srs_pkg::BIT_LAST) begin
            ack_q <= 1'b1;
            case (state_q)
               srs_pkg::SRS_DEVADR: begin
                  if (rx_byte[7:1] == my_addr) begin
                     rw_q <= rx_byte[0];
                     if (rx_byte[0]) begin
                        state_q   <= srs_pkg::SRS_RDATA;
                        rd_addr_q <= ptr_q;
                        rd_t_q    <= ~rd_t_q;
                        adr_ack_q <= 1'b1;
                     end else begin
                        state_q <= srs_pkg::SRS_ADRHI;
                     end
                  end else begin
                     state_q <= srs_pkg::SRS_IGNORE;
                     ack_q   <= 1'b0;
                  end
               end
               srs_pkg::SRS_ADRHI: begin
                  ptr_q[15:8] <= rx_byte;
                  state_q     <= srs_pkg::SRS_ADRLO;
               end
               srs_pkg::SRS_ADRLO: begin
                  ptr_q[7:0] <= rx_byte;
                  state_q    <= srs_pkg::SRS_WDATA;
               end
               srs_pkg::SRS_WDATA: begin
                  wr_addr_q <= ptr_q;
                  wr_data_q <= rx_byte;
                  wr_t_q    <= ~wr_t_q;
                  ptr_q     <= ptr_q + 16'h0001;
               end
               srs_pkg::SRS_RDATA: begin
                  ptr_q     <= ptr_q + 16'h0001;
                  ack_q     <= 1'b1;
                  adr_ack_q <= 1'b0;
               end
               default: begin
                  state_q <= srs_pkg::SRS_IGNORE;
               end
            endcase
         end
         if (state_q == srs_pkg::SRS_RDATA && bit_q == srs_pkg::BIT_LAST) begin
            rd_addr_q <= ptr_q + 16'h0001;
            rd_t_q    <= ~rd_t_q;
         end
      end
   end

   // data drive on falling serial clock
   always_ff @(negedge scl or negedge nrst) begin
      if (!nrst) begin
         drive_q <= 1'b0;
         sda_o   <= 1'b0;
         tx_q    <= srs_pkg::BYTE_RESET;
      end else if (start_ack_q != start_t_q) begin
         drive_q <= 1'b0;
      end else if (ack_q && state_q != srs_pkg::SRS_RDATA) begin
         drive_q <= 1'b1;
         sda_o   <= 1'b0;
      end else if (ack_q && state_q == srs_pkg::SRS_RDATA && rw_q && adr_ack_q) begin
         drive_q <= 1'b1;
         sda_o   <= 1'b0;
      end else if (state_q == srs_pkg::SRS_RDATA && !ack_q) begin
         if (bit_q == srs_pkg::CNT_RESET) begin
            tx_q    <= {rdata_s_q[6:0], 1'b0};
            sda_o   <= rdata_s_q[7];
         end else begin
            tx_q  <= {tx_q[6:0], 1'b0};
            sda_o <= tx_q[7];
         end
         drive_q <= 1'b1;
      end else begin
         drive_q <= 1'b0;
         sda_o   <= 1'b0;
      end
   end

   assign sda_oe = drive_q & ~sda_o;

   // read data held stable in clk domain; sampled here after handshake settles
   logic [7:0] rdata_hold_q;
   always_ff @(posedge scl or negedge nrst) begin
      if (!nrst) begin
         rdata_s_q <= srs_pkg::BYTE_RESET;
      end else begin
         rdata_s_q <= rdata_hold_q;
      end
   end

   // system domain: toggles crossed with two flops
   logic [3:0] toggles_s;
   logic [3:0] toggles_last_q;
   logic       rd_pend_q;

   // bit 3 write, bit 2 read, bit 1 start, bit 0 stop
   srs_sync #(.WIDTH(4)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({wr_t_q, rd_t_q, start_t_q, stop_t_q}),
      .q    (toggles_s)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         toggles_last_q <= 4'h0;
      end else if (ce) begin
         toggles_last_q <= toggles_s;
      end
   end

   // register port strobes, one ce-enabled clk cycle each
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_we    <= 1'b0;
         reg_rd    <= 1'b0;
         reg_addr  <= srs_pkg::PTR_RESET;
         reg_wdata <= srs_pkg::BYTE_RESET;
      end else if (ce) begin
         reg_we <= toggles_s[3] ^ toggles_last_q[3];
         reg_rd <= toggles_s[2] ^ toggles_last_q[2];
         if (toggles_s[3] ^ toggles_last_q[3]) begin
            reg_addr  <= wr_addr_q;
            reg_wdata <= wr_data_q;
         end else if (toggles_s[2] ^ toggles_last_q[2]) begin
            reg_addr <= rd_addr_q;
         end
      end
   end

   // read data stands the cycle after the read strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_pend_q    <= 1'b0;
         rdata_hold_q <= srs_pkg::BYTE_RESET;
      end else if (ce) begin
         rd_pend_q <= reg_rd;
         if (rd_pend_q) begin
            rdata_hold_q <= reg_rdata;
         end
      end
   end

   // busy spans start to stop; a start wins over a stop seen together
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_frame_q <= 1'b0;
         busy       <= 1'b0;
      end else if (ce) begin
         if (toggles_s[1] ^ toggles_last_q[1]) begin
            in_frame_q <= 1'b1;
         end else if (toggles_s[0] ^ toggles_last_q[0]) begin
            in_frame_q <= 1'b0;
         end
         busy <= in_frame_q;
      end
   end
endmodule

/* dv/srs_slave_monitor.sv */
// checker: port assertions for the serial register slave
`timescale 1ns/1ps
module srs_slave_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic reg_we,
   input wire logic reg_rd,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence we_quiet; !reg_we [*8]; endsequence
   sequence rd_quiet; !reg_rd [*8]; endsequence
   sequence scl_held; scl ##1 scl; endsequence
   oe_low_a: assert property ($fell(busy) |-> !sda_oe && !sda_o) else $error("end drive");
   oe_edge_a: assert property ($changed(sda_oe) |-> !scl) else $error("scl high");
   oe_hold_a: assert property (scl_held |-> $stable(sda_oe)) else $error("oe moved");
   we_gap_a: assert property (reg_we |=> we_quiet) else $error("we");
   rd_gap_a: assert property (reg_rd |=> rd_quiet) else $error("rd");
   acc_excl_a: assert property (!(reg_we && reg_rd)) else $error("we rd");
   acc_busy_a: assert property (reg_we || reg_rd |-> busy) else $error("busy");
   idle_drive_a: assert property (!busy |-> !sda_oe) else $error("idle drive");
endmodule
bind srs_slave srs_slave_monitor mon (.clk(clk), .nrst(nrst), .scl(scl), .sda_o(sda_o),
   .sda_oe(sda_oe), .reg_we(reg_we), .reg_rd(reg_rd), .busy(busy));

/* dv/srs_master.sv */
// partner model: bus master driving the serial clock and pulling data low
`timescale 1ns/1ps
module srs_master (
   output logic      scl = 1'b1,
   output logic      sda_low = 1'b0,
   input  wire logic sda
);
   task automatic start();
      #1.3; // keeps serial clock edges off the system clock edges
      sda_low = 1'b0;
      #10 scl = 1'b1;
      #10 sda_low = 1'b1;
      #10 scl = 1'b0;
      #10;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #10 scl = 1'b1;
      #10 sda_low = 1'b0;
      #10;
   endtask
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         sda_low = !d[i];
         #10 scl = 1'b1;
         #5 q[i] = sda;
         #5 scl = 1'b0;
         #10;
      end
   endtask
endmodule

/* dv/srs_slave_tb.sv */
// testbench: serial register slave against the bus master model
`timescale 1ns/1ps
module srs_slave_tb;
   localparam logic [7:0] WA = {srs_pkg::ADDR_DEFAULT, 1'b0};
   localparam logic [7:0] RA = {srs_pkg::ADDR_DEFAULT, 1'b1};
   localparam logic [7:0] AW = {srs_pkg::ADDR_ALT, 1'b0};
   logic        clk = 1'b0, nrst = 1'b0, alt_en = 1'b0, alt_sel = 1'b0;
   logic        sda_o, sda_oe, we, rd, busy, scl, m_low;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata = 8'h00;
   logic [8:0]  v;
   logic [7:0]  mem [logic [15:0]];
   int          errors, comparisons;
   wire         sda = !(m_low || (sda_oe && !sda_o));
   srs_slave dut (.clk(clk), .nrst(nrst), .ce(1'b1), .scl(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .alt_addr_en(alt_en), .alt_addr_sel(alt_sel),
      .reg_addr(addr), .reg_wdata(wdata), .reg_we(we), .reg_rd(rd), .reg_rdata(rdata),
      .busy(busy));
   srs_master m (.scl(scl), .sda_low(m_low), .sda(sda));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (we) mem[addr] = wdata;
   always @(posedge clk) if (rd) rdata <= mem.exists(addr) ? mem[addr] : addr[7:0] ^ 8'h5a;
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      errors += int'(g !== e);
      if (g !== e) $display("BAD t=%0t got=%h exp=%h", $time, g, e);
   endtask
   task automatic wb(input logic [7:0] d, input logic n);
      m.xfer({d, 1'b1}, v);
      chk({7'h00, v[0]}, {7'h00, n});
   endtask
   task automatic rb(input logic [7:0] e, input logic last);
      m.xfer({8'hff, last}, v);
      chk(v[8:1], e);
   endtask
   task automatic hd(input logic [7:0] d, input logic n);
      m.start();
      wb(d, n);
   endtask
   task automatic t_write();
      hd(WA, 1'b0);
      wb(8'h12, 1'b0);
      chk({7'h00, busy}, 8'h01);
      wb(8'h34, 1'b0);
      wb(8'ha5, 1'b0);
      wb(8'hb6, 1'b0);
      m.stop();
      chk(mem[16'h1234], 8'ha5);
      chk(mem[16'h1235], 8'hb6);
      repeat (6) @(posedge clk);
      chk({7'h00, busy}, 8'h00);
   endtask
   task automatic t_read();
      hd(WA, 1'b0);
      wb(8'h12, 1'b0);
      wb(8'h34, 1'b0);
      hd(RA, 1'b0);
      rb(8'ha5, 1'b0);
      rb(8'hb6, 1'b1);
      m.stop();
      hd(RA, 1'b0);
      rb(8'h36 ^ 8'h5a, 1'b1);
      m.stop();
      hd(RA, 1'b0);
      rb(8'h37 ^ 8'h5a, 1'b0);
      rb(8'h38 ^ 8'h5a, 1'b1);
      m.stop();
   endtask
   task automatic t_alt();
      hd(AW, 1'b1);
      wb(8'h12, 1'b1);
      m.stop();
      @(posedge clk);
      alt_en <= 1'b1;
      alt_sel <= 1'b1;
      repeat (4) @(posedge clk);
      hd(WA, 1'b1);
      m.stop();
      hd(AW, 1'b0);
      m.stop();
   endtask
   task automatic final_report();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_write();
      t_read();
      t_alt();
      final_report();
   end
   initial begin
      #100000;
      errors++;
      final_report();
   end
endmodule
